// file: hdl/mds_consts.svh
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH
// ----------------------------------------
// Microinstruction word fields
// ----------------------------------------
`define UI_OP_HI 31
`define UI_OP_LO 28
`define UI_SKIP 27
`define UI_RF_HI 23
`define UI_RF_LO 20
`define UI_SF_HI 19
`define UI_SF_LO 16
`define UI_TGT_HI 15
`define UI_TGT_LO 0
// ----------------------------------------
// Lookup word fields
// ----------------------------------------
`define LT_SA_HI 19
`define LT_SA_LO 8
`define LT_STACK_PREADJUST_BIT2 7
`define LT_STACK_PREADJUST_BIT1 6
`define LT_STACK_PREADJUST_BIT0 5
`define LT_Z 4
`define LT_PC0 3
`define LT_PC1 2
`define LT_W 1
`define LT_LJ 0
// ----------------------------------------
// Mapper slices of the decode source
// ----------------------------------------
`define MAP_IN_HI 15
`define MAP_IN_LO 6
`define MAP_KEEP_HI 9
`define MAP_KEEP_LO 3
`define MAP_CTL_HI 15
`define MAP_CTL_LO 8
`define MAP_CLS_HI 7
`define MAP_CLS_LO 4
`define MREF_MIN 4'h4
// ----------------------------------------
// Register map and bus answers
// ----------------------------------------
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_MADDR 8'h08
`define A_PTR 8'h0c
`define A_UDATA 8'h10
`define A_LDATA 8'h14
`define A_CUR_INSTR 8'h18
`define CTRL_RUN 0
`define CTRL_RST 1'h0
`define STRB_ALL 4'hf
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ONE16 16'h0001
`endif

// file: hdl/mds_pkg.sv
package mds_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MAP = 2'b01,
        ST_LUT = 2'b10,
        ST_RUN = 2'b11
    } seq_state_t;
    // Microinstruction operation codes
    typedef enum logic [3:0] {
        OP_STEP = 4'b0000,
        OP_JMP = 4'b0001,
        OP_CJMP = 4'b0010,
        OP_LUJ = 4'b0011,
        OP_NEXT = 4'b0100
    } micro_op_t;
endpackage

// file: hdl/micro_mem.sv
`timescale 1ns/1ns
`default_nettype none

module micro_mem #(
    parameter int WIDTH = 32,
    parameter int AW = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_r
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write port, loaded by software before the sequencer runs
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read; reset word is zero, which decodes as a plain step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[raddr];
        end
    end
endmodule // micro_mem

`default_nettype wire

// file: hdl/microcode_dispatch_sequencer.sv
// What this block does
// - Fetched instruction words land in next_instr_reg before moving onward.
// - Unfilled pipeline: next_instr_reg feeds current register and decode mux directly.
// - Decode mux gives ten mapper bits, eight control bits; 8-bit result addresses lookup.
// - Lookup word gives 12-bit start address plus eight control bits.
// - Start address enters address select mux; 16-bit output feeds ROM and incrementer.
// - Start address is used as first address only once preadjust needs are met.
// - The 32-bit microcode word is registered into micro_stage1_reg.
// - Same edge stores incremented address in next_microaddr_reg, fed back to select.
// - Each cycle fetches the next word while stage1 advances into stage2.
// - Unconditional target comes from stage1 fields, or stage2 after a skip.
// - After an unconditional jump, target plus one enters next_microaddr_reg.
// - Conditional jump in stage1 decodes R and S fields toward bus registers.
// - Next cycle the jump moves to stage2 and R and S registers load.
// - Conditional target is taken from stage2 and presented to the ROM.
// - On the conditional target fetch, target plus one enters next_microaddr_reg.
// - Three preadjust bits say how many stack registers must be valid.
// - Width bit modifies lookup address on lookup jump of a memory-reference word, so dispatch does not loop.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mds_consts.svh"

module microcode_dispatch_sequencer
    import mds_pkg::*;
#(
    parameter int UCODE_AW = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic instr_req_r,
    input wire logic instr_valid,
    input wire logic [15:0] instr_data,
    input wire logic [2:0] tos_valid_count,
    input wire logic [15:0] cond_flags,
    output logic [15:0] next_instr_reg,
    output logic [15:0] current_instr_reg,
    output wire logic [31:0] micro_stage1_reg,
    output logic [31:0] micro_stage2_reg,
    output logic [15:0] next_microaddr_reg,
    output logic [15:0] rbus_reg_r,
    output logic [15:0] sbus_reg_r,
    output logic stack_preadjust_bit0,
    output logic stack_preadjust_bit1,
    output logic stack_preadjust_bit2,
    output logic preadder_zero,
    output logic preadder_ctrl_bit0,
    output logic preadder_ctrl_bit1,
    output logic preadder_width,
    output logic lookup_jump_bit
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    seq_state_t state_r, state_nxt;
    logic next_full_r, bypass_r, lookup_pass_r, width_bit_r, ctrl_run_r;
    logic stage1_valid_r, stage2_valid_r;
    logic [15:0] load_ptr_r, decode_source_mux, microaddr_select_mux;
    logic [19:0] lut_word;
    logic [7:0] lut_addr;
    logic [9:0] map_in;
    logic [7:0] map_ctl;
    logic [2:0] srp_need;
    logic [15:0] lut_start, s1_tgt, s2_tgt, ujmp_tgt;
    logic [3:0] s1_rf, s1_sf;
    micro_op_t op1, op2;
    logic s1_act, stop_op, preadj_ok, fetch_en, take_next, next_go;
    logic ujmp, cjmp_taken, s2_skip, mref, wmod;
    logic aw_full_r, w_full_r, do_wr, full_strb, wr_known, rd_known;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rd_mux;
    logic [3:0] wstrb_q;

    // ----------------------------------------
    // Instruction registers and decode source
    // ----------------------------------------
    assign next_go = s1_act && op1 == OP_NEXT && next_full_r;
    assign take_next = (state_r == ST_MAP && bypass_r) || next_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_instr_reg <= '0;
            next_full_r <= 1'b0;
            instr_req_r <= 1'b0;
        end else begin
            if (instr_valid && !next_full_r) begin
                next_instr_reg <= instr_data;
                next_full_r <= 1'b1;
            end else if (take_next) begin
                next_full_r <= 1'b0;
            end
            // Lags one cycle after emptying; a word offered while full is dropped
            instr_req_r <= !next_full_r && !instr_valid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            current_instr_reg <= '0;
        end else if (take_next) begin
            current_instr_reg <= next_instr_reg;
        end
    end

    assign decode_source_mux = bypass_r ? next_instr_reg : current_instr_reg;

    assign map_in = decode_source_mux[`MAP_IN_HI:`MAP_IN_LO];
    assign map_ctl = decode_source_mux[`MAP_CTL_HI:`MAP_CTL_LO];
    assign mref = map_ctl[`MAP_CLS_HI:`MAP_CLS_LO] >= `MREF_MIN;
    assign wmod = mref && lookup_pass_r && width_bit_r;
    assign lut_addr = {map_in[`MAP_KEEP_HI:`MAP_KEEP_LO], wmod};

    // Lookup table, software loaded
    micro_mem #(.WIDTH(20), .AW(8)) u_lut (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(do_wr && full_strb && awaddr_q == `A_LDATA),
        .waddr(load_ptr_r[7:0]),
        .wdata(wdata_q[`LT_SA_HI:0]),
        .raddr(lut_addr),
        .rdata_r(lut_word)
    );

    assign lut_start = {4'h0, lut_word[`LT_SA_HI:`LT_SA_LO]};
    assign srp_need = {lut_word[`LT_STACK_PREADJUST_BIT2], lut_word[`LT_STACK_PREADJUST_BIT1], lut_word[`LT_STACK_PREADJUST_BIT0]};
    assign preadj_ok = tos_valid_count >= srp_need;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {stack_preadjust_bit2, stack_preadjust_bit1, stack_preadjust_bit0} <= '0;
            {preadder_zero, preadder_ctrl_bit0, preadder_ctrl_bit1, preadder_width} <= '0;
            lookup_jump_bit <= 1'b0;
            width_bit_r <= 1'b0;
        end else if (state_r == ST_LUT && preadj_ok) begin
            {stack_preadjust_bit2, stack_preadjust_bit1, stack_preadjust_bit0} <= srp_need;
            preadder_zero <= lut_word[`LT_Z];
            preadder_ctrl_bit0 <= lut_word[`LT_PC0];
            preadder_ctrl_bit1 <= lut_word[`LT_PC1];
            preadder_width <= lut_word[`LT_W];
            lookup_jump_bit <= lut_word[`LT_LJ];
            width_bit_r <= lut_word[`LT_W];
        end
    end

    // ----------------------------------------
    // Sequencer state machine
    // ----------------------------------------
    assign op1 = micro_op_t'(micro_stage1_reg[`UI_OP_HI:`UI_OP_LO]);
    assign op2 = micro_op_t'(micro_stage2_reg[`UI_OP_HI:`UI_OP_LO]);
    assign s1_act = stage1_valid_r && state_r == ST_RUN;
    assign stop_op = s1_act && (op1 == OP_NEXT || op1 == OP_LUJ);
    // start only once preadjust is met
    assign fetch_en = (state_r == ST_LUT && preadj_ok) || (state_r == ST_RUN && !stop_op);

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (ctrl_run_r && next_full_r) begin
                    state_nxt = ST_MAP;
                end
            end
            ST_MAP: state_nxt = ST_LUT;
            ST_LUT: begin
                if (preadj_ok) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_op) begin
                    state_nxt = (op1 == OP_LUJ || next_full_r) ? ST_MAP : ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            bypass_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bypass_r <= state_r == ST_IDLE && state_nxt == ST_MAP;
        end
    end

    // Lookup pass flag; held until the next instruction dispatch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lookup_pass_r <= 1'b0;
        end else if (stop_op && op1 == OP_LUJ) begin
            lookup_pass_r <= 1'b1;
        end else if (take_next) begin
            lookup_pass_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Microaddress selection and stages
    // ----------------------------------------
    assign s1_tgt = micro_stage1_reg[`UI_TGT_HI:`UI_TGT_LO];
    assign s2_tgt = micro_stage2_reg[`UI_TGT_HI:`UI_TGT_LO];
    assign s1_rf = micro_stage1_reg[`UI_RF_HI:`UI_RF_LO];
    assign s1_sf = micro_stage1_reg[`UI_SF_HI:`UI_SF_LO];
    assign s2_skip = stage2_valid_r && micro_stage2_reg[`UI_SKIP];
    assign ujmp_tgt = s2_skip ? s2_tgt : s1_tgt;
    assign ujmp = s1_act && op1 == OP_JMP;
    assign cjmp_taken = stage2_valid_r && op2 == OP_CJMP &&
        (|((rbus_reg_r & cond_flags) | (sbus_reg_r & ~cond_flags)));

    // select lookup start, jump target or incremented address
    always_comb begin
        microaddr_select_mux = next_microaddr_reg;
        if (state_r == ST_LUT) begin
            microaddr_select_mux = lut_start;
        end else if (cjmp_taken) begin
            microaddr_select_mux = s2_tgt;
        end else if (ujmp) begin
            microaddr_select_mux = ujmp_tgt;
        end
    end

    micro_mem #(.WIDTH(32), .AW(UCODE_AW)) u_ucode (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(do_wr && full_strb && awaddr_q == `A_UDATA),
        .waddr(load_ptr_r[UCODE_AW-1:0]),
        .wdata(wdata_q),
        .raddr(microaddr_select_mux[UCODE_AW-1:0]),
        .rdata_r(micro_stage1_reg)
    );

    // address plus one on the fetch edge; too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_microaddr_reg <= '0;
        end else if (fetch_en) begin
            next_microaddr_reg <= microaddr_select_mux + `ONE16;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_valid_r <= 1'b0;
            stage2_valid_r <= 1'b0;
            micro_stage2_reg <= '0;
        end else begin
            stage1_valid_r <= fetch_en;
            stage2_valid_r <= s1_act;
            micro_stage2_reg <= micro_stage1_reg;
        end
    end

    // decode R and S fields; registers load as jump enters stage2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rbus_reg_r <= '0;
            sbus_reg_r <= '0;
        end else if (s1_act && op1 == OP_CJMP) begin
            rbus_reg_r <= `ONE16 << s1_rf;
            sbus_reg_r <= `ONE16 << s1_sf;
        end else begin
            rbus_reg_r <= '0;
            sbus_reg_r <= '0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign do_wr = aw_full_r && w_full_r && !bvalid;
    assign full_strb = wstrb_q == `STRB_ALL;
    assign wr_known = awaddr_q == `A_CTRL || awaddr_q == `A_PTR ||
        awaddr_q == `A_UDATA || awaddr_q == `A_LDATA;

    // Address and data are held apart so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_full_r <= 1'b1;
                awaddr_q <= awaddr;
            end else if (do_wr) begin
                aw_full_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_r <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (do_wr) begin
                w_full_r <= 1'b0;
            end
            awready <= !aw_full_r && !(awvalid && awready) && !bvalid;
            wready <= !w_full_r && !(wvalid && wready) && !bvalid;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control and load pointer; partial strobes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_run_r <= `CTRL_RST;
            load_ptr_r <= '0;
        end else if (do_wr && full_strb) begin
            if (awaddr_q == `A_CTRL) begin
                ctrl_run_r <= wdata_q[`CTRL_RUN];
            end else if (awaddr_q == `A_PTR) begin
                load_ptr_r <= wdata_q[`UI_TGT_HI:`UI_TGT_LO];
            end else if (awaddr_q == `A_UDATA || awaddr_q == `A_LDATA) begin
                load_ptr_r <= load_ptr_r + `ONE16;
            end
        end
    end

    // Read decode
    always_comb begin
        rd_mux = '0;
        rd_known = 1'b1;
        if (araddr == `A_CTRL) begin
            rd_mux = {31'h0, ctrl_run_r};
        end else if (araddr == `A_STATUS) begin
            rd_mux = {26'h0, stage1_valid_r, width_bit_r, lookup_pass_r, next_full_r, state_r};
        end else if (araddr == `A_MADDR) begin
            rd_mux = {16'h0, next_microaddr_reg};
        end else if (araddr == `A_PTR) begin
            rd_mux = {16'h0, load_ptr_r};
        end else if (araddr == `A_CUR_INSTR) begin
            rd_mux = {16'h0, current_instr_reg};
        end else if (araddr != `A_UDATA && araddr != `A_LDATA) begin
            rd_known = 1'b0;
        end
    end

    // Read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_next_capture: assert property (instr_valid && !next_full_r |=>
        next_full_r && next_instr_reg == $past(instr_data)) else $error("word not captured");
    a_bypass_source: assert property (state_r == ST_MAP && bypass_r |->
        decode_source_mux == next_instr_reg ##1 current_instr_reg == $past(next_instr_reg))
        else $error("bypass path wrong");
    a_lut_bits: assert property (state_r == ST_LUT && preadj_ok |=>
        stack_preadjust_bit2 == $past(lut_word[`LT_STACK_PREADJUST_BIT2]) && lookup_jump_bit == $past(lut_word[`LT_LJ]))
        else $error("lookup bits not latched");
    a_start_addr: assert property (state_r == ST_LUT && preadj_ok |=>
        next_microaddr_reg == $past(lut_start) + `ONE16 && stage1_valid_r) else $error("start address wrong");
    a_preadj_hold: assert property (state_r == ST_LUT && !preadj_ok |=>
        state_r == ST_LUT && !stage1_valid_r) else $error("started before preadjust");
    a_seq_step: assert property (fetch_en && state_r == ST_RUN && !ujmp && !cjmp_taken |=>
        next_microaddr_reg == $past(next_microaddr_reg) + `ONE16) else $error("no sequential step");
    a_stage_move: assert property (s1_act |=> stage2_valid_r &&
        micro_stage2_reg == $past(micro_stage1_reg)) else $error("stage2 not advanced");
    a_ujmp_target: assert property (fetch_en && ujmp && !cjmp_taken |=>
        next_microaddr_reg == $past(ujmp_tgt) + `ONE16) else $error("jump target wrong");
    a_cjmp_decode: assert property (s1_act && op1 == OP_CJMP |=>
        rbus_reg_r == `ONE16 << $past(s1_rf) && sbus_reg_r == `ONE16 << $past(s1_sf))
        else $error("R S registers wrong");
    a_cjmp_target: assert property (fetch_en && cjmp_taken |=>
        next_microaddr_reg == $past(s2_tgt) + `ONE16) else $error("conditional target wrong");
    a_width_mod: assert property (state_r == ST_MAP && lookup_pass_r && width_bit_r && mref |->
        lut_addr[0] ##1 state_r == ST_LUT) else $error("width bit not applied");
    a_reset_empty: assert property ($rose(next_full_r) && state_r == ST_IDLE && ctrl_run_r |=>
        state_r == ST_MAP && bypass_r) else $error("empty pipeline not bypassed");

    c_bypass: cover property (state_r == ST_MAP && bypass_r);
    c_ujmp: cover property (fetch_en && ujmp);
    c_cjmp: cover property (fetch_en && cjmp_taken);
    c_remap: cover property (state_r == ST_MAP && wmod);
    c_stall: cover property (state_r == ST_LUT && !preadj_ok ##1 preadj_ok);
endmodule // microcode_dispatch_sequencer

`default_nettype wire

// file: bench/instr_source_model.sv
`timescale 1ns/1ns
`default_nettype none

module instr_source_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic send,
    input wire logic [15:0] word,
    input wire logic instr_req_r,
    output logic instr_valid,
    output logic [15:0] instr_data
);
    logic pend_r;

    // Offer each word for one cycle, only once the block asks for it
    // Idle data toggles so a stale word never looks valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'b0;
            instr_valid <= 1'b0;
            instr_data <= 16'h0000;
        end else if (pend_r && instr_req_r) begin
            pend_r <= 1'b0;
            instr_valid <= 1'b1;
            instr_data <= word;
        end else begin
            pend_r <= pend_r | send;
            instr_valid <= 1'b0;
            instr_data <= ~instr_data;
        end
    end
endmodule // instr_source_model

`default_nettype wire

// file: bench/microcode_dispatch_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "mds_consts.svh"

module microcode_dispatch_sequencer_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic instr_req_r, instr_valid, send, stack_preadjust_bit0, stack_preadjust_bit1, stack_preadjust_bit2;
    logic preadder_zero, preadder_ctrl_bit0, preadder_ctrl_bit1, preadder_width, lookup_jump_bit;
    logic [7:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] tos_valid_count;
    logic [31:0] wdata, rdata, micro_stage1_reg, micro_stage2_reg;
    logic [15:0] cond_flags, instr_data, word, next_instr_reg, current_instr_reg, next_microaddr_reg;
    logic [15:0] rbus_reg_r, sbus_reg_r;
    int n_errors = 0;
    int checks_done = 0;
    // Pointer, microcode and lookup writes as {address, data}
    localparam logic [39:0] PROG [16] = '{40'h0c00000010, 40'h1000000aa1, 40'h1010000020, 40'h1000000bb2,
        40'h0c00000020, 40'h1020300030, 40'h1000000cc1, 40'h0c00000030, 40'h1040000000, 40'h0c00000004,
        40'h1400001048, 40'h0c00000040, 40'h1400005002, 40'h1400003001, 40'h0c00000050, 40'h1030000000};

    microcode_dispatch_sequencer i_dut (.*);
    instr_source_model i_src (.aclk, .aresetn, .send, .word, .instr_req_r, .instr_valid, .instr_data);

    // Processor clock, 100 ns period
    always #50 aclk = ~aclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A wait that runs out counts as a mismatch and ends the run
    task limit(input int i);
        if (i >= 100) begin
            n_errors++;
            $display("Error at %0t: waited %h cycles, limit %h", $time, i, 100);
            summarize;
        end
    endtask

    task tick;
        @(posedge aclk);
        #1;
    endtask

    // Address and data go out together; bready stays up until the answer
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        r = bresp;
        limit(i);
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        limit(i);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        repeat (15) @(posedge aclk);
        #1;
        chk({bvalid, next_microaddr_reg}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) tick;
        chk({instr_req_r, awready}, 32'h3);
        $display("Reset test done");
    endtask

    // Unmapped and read-only places must be refused
    task t_bus;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`A_CTRL, d, r);
        chk({d[29:0], r}, {30'h0, `RESP_OKAY});
        axi_wr(8'h40, 32'h1, r);
        chk(r, `RESP_SLVERR);
        axi_rd(8'h40, d, r);
        chk({d[29:0], r}, {30'h0, `RESP_SLVERR});
        axi_wr(`A_STATUS, 32'h1, r);
        chk(r, `RESP_SLVERR);
        $display("Bus test done");
    endtask

    // Too few valid stack words: dispatch must wait in lookup
    task t_hold;
        logic [31:0] d;
        logic [1:0] r;
        int i;
        foreach (PROG[k]) begin
            axi_wr(PROG[k][39:32], PROG[k][31:0], r);
            chk(r, `RESP_OKAY);
        end
        axi_wr(`A_CTRL, 32'h1, r);
        @(posedge aclk);
        word <= 16'h0400;
        send <= 1'b1;
        @(posedge aclk);
        send <= 1'b0;
        for (i = 0; i < 100 && next_instr_reg !== 16'h0400; i++)
            tick;
        limit(i);
        chk(next_instr_reg, 16'h0400);
        repeat (8) tick;
        axi_rd(`A_STATUS, d, r);
        chk({d[5], d[1:0]}, 3'b010);
        $display("Hold test done");
    endtask

    // Dispatch, sequential step, jump and conditional jump
    task t_run;
        int i;
        @(posedge aclk);
        tos_valid_count <= 3'd2;
        for (i = 0; i < 100 && preadder_ctrl_bit0 !== 1'b1; i++)
            tick;
        limit(i);
        chk(current_instr_reg, 16'h0400);
        chk(micro_stage1_reg, 32'h0aa1);
        chk(next_microaddr_reg, 16'h0011);
        chk({stack_preadjust_bit2, stack_preadjust_bit1, stack_preadjust_bit0}, 3'd2);
        chk({preadder_zero, preadder_ctrl_bit0, preadder_ctrl_bit1, preadder_width, lookup_jump_bit}, 5'h08);
        tick;
        chk(micro_stage1_reg, 32'h10000020);
        chk({micro_stage2_reg[15:0], next_microaddr_reg}, 32'h0aa10012);
        tick;
        chk(micro_stage1_reg, 32'h20300030);
        chk(next_microaddr_reg, 16'h0021);
        tick;
        chk(micro_stage2_reg, 32'h20300030);
        chk({rbus_reg_r, sbus_reg_r}, 32'h00080001);
        chk(micro_stage1_reg, 32'h0cc1);
        tick;
        chk(micro_stage1_reg, 32'h40000000);
        chk(next_microaddr_reg, 16'h0031);
        $display("Run test done");
    endtask

    // Memory-reference word: the lookup jump must remap through the width bit, not loop
    task t_remap;
        int i;
        @(posedge aclk);
        word <= 16'h4000;
        send <= 1'b1;
        @(posedge aclk);
        send <= 1'b0;
        for (i = 0; i < 100 && lookup_jump_bit !== 1'b1; i++)
            tick;
        limit(i);
        chk(next_microaddr_reg, 16'h0031);
        chk(micro_stage1_reg, 32'h40000000);
        chk(current_instr_reg, 16'h4000);
        $display("Remap test done");
    endtask

    // Inputs settled at time zero, then the scenarios in order
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, send} = 8'h00;
        {awaddr, araddr, wdata, word} = 64'h0;
        wstrb = `STRB_ALL;
        tos_valid_count = 3'd1;
        cond_flags = 16'h0008;
        t_reset;
        t_bus;
        t_hold;
        t_run;
        t_remap;
        summarize;
    end
endmodule // microcode_dispatch_sequencer_tb

`default_nettype wire
